// File: mfc_unit.sv
// Function
// - Translation off allows only alignment and direct-store error data faults.
// - Zero-block to write-through or inhibited with translation on faults alignment.
// - Zero-block with data cache locked faults alignment.
// - Reservation to write-through gives storage fault bit5.
// - Reservation or external I/O to direct-store: bit5.
// - Floating-point access to direct-store faults alignment.
// - Direct-store protocol error gives storage fault bit0.
// - External I/O with access disabled: bit11.
// - Multiple or string in little-endian faults alignment.
// - Misaligned load, store, floating-point or reservation operand with translation on faults alignment.
// - Invalidate-all traps as illegal; others supported.
// - Move-to-segment writes direct or indirect index.
// - Move-from-segment reads direct or indirect index.
// - Entry invalidate clears class locally and broadcasts.
// - Sync is a distinct bus transaction; snoopers synchronise.
// - Segment type bit selects direct-store access path.
// - Sixteen 32-bit segment registers.
// Memory-management fault detector, segment registers and TLB bus operations.
// Assumes one instruction per req_valid_i cycle from the core; bus and error pins are asynchronous.
`timescale 1ns/1ps
`include "mfc_regs.svh"
module mfc_unit (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic req_valid_i,
   input wire mfc_pkg::mfc_op_t req_op_i,
   input wire logic [31:0] req_ea_i,
   input wire logic [1:0] req_size_i,
   input wire logic [31:0] req_rs_i,
   input wire logic [31:0] req_rb_i,
   input wire logic [3:0] req_sr_i,
   input wire logic attr_wt_i,
   input wire logic attr_ci_i,
   input wire logic data_translate_enable_i,
   input wire logic little_endian_mode_i,
   input wire logic ext_access_enable_i,
   input wire logic [31:0] hw_impl_config_i,
   input wire logic ds_err_i,
   input wire logic bus_gnt_i,
   input wire logic snoop_inv_i,
   input wire logic snoop_sync_i,
   input wire logic [31:0] snoop_addr_i,
   output logic req_ready_o,
   output logic align_exc_o,
   output logic dsi_exc_o,
   output logic [31:0] data_fault_status_o,
   output logic illegal_o,
   output logic rd_valid_o,
   output logic [31:0] rd_data_o,
   output logic mem_ok_o,
   output logic ds_access_o,
   output logic tlb_inval_o,
   output logic [5:0] tlb_inval_idx_o,
   output logic snoop_sync_o,
   output logic bus_req_o,
   output mfc_pkg::mfc_bus_t bus_cmd_o,
   output logic [31:0] bus_addr_o
);
   // Pin synchroniser bit order: ds error, grant, snoop invalidate, snoop sync.
   typedef struct packed {
      mfc_pkg::mfc_st_t st;
      logic [15:0][31:0] seg;
      logic [3:0] sa;
      logic [3:0] sb;
      logic [3:0] sc;
      logic [31:0] saddr_a;
      logic [31:0] saddr_b;
      logic ready;
      logic align;
      logic dsi;
      logic [31:0] dfs;
      logic illegal;
      logic rd_valid;
      logic [31:0] rd_data;
      logic mem_ok;
      logic ds_acc;
      logic inval;
      logic [5:0] inval_idx;
      logic ssync;
      logic bus_req;
      mfc_pkg::mfc_bus_t bus_cmd;
      logic [31:0] bus_addr;
   } mfc_state_t;

   mfc_state_t s_ff;
   mfc_state_t nxt_s;

   logic take;
   logic dte;
   logic seg_t;
   logic lock;
   logic misal;
   logic ds_ev;
   logic inv_ev;
   logic [31:0] sel_val;
   logic [3:0] sel_idx;
   logic mem_op;
   logic fp_op;
   logic resv_op;
   logic ext_op;
   logic f_align;
   logic f_dsi;
   logic [31:0] f_dfs;

   assign take = req_valid_i && s_ff.ready;
   assign dte = data_translate_enable_i;
   assign ds_ev = s_ff.sb[0] && !s_ff.sc[0];
   assign inv_ev = s_ff.sb[2] && !s_ff.sc[2];
   assign lock = hw_impl_config_i[`MFC_CFG_LOCK_A] && hw_impl_config_i[`MFC_CFG_LOCK_B];
   assign seg_t = s_ff.seg[req_ea_i[`MFC_SEG_HI:`MFC_SEG_LO]][`MFC_SEG_T];
   assign fp_op = req_op_i inside {mfc_pkg::OP_FP_LOAD, mfc_pkg::OP_FP_STORE};
   assign resv_op = req_op_i inside {mfc_pkg::OP_LOAD_RESERVE, mfc_pkg::OP_STORE_COND};
   assign ext_op = req_op_i inside {mfc_pkg::OP_EXT_IN, mfc_pkg::OP_EXT_OUT};
   assign mem_op = fp_op || resv_op || ext_op || req_op_i inside {mfc_pkg::OP_LOAD,
      mfc_pkg::OP_STORE, mfc_pkg::OP_MULTI_STRING, mfc_pkg::OP_ZERO_BLOCK};
   // Natural alignment is the chosen misalignment policy for sized operands.
   assign misal = (req_ea_i[2:0] & ((3'h1 << req_size_i) - 3'h1)) != 3'h0;
   assign sel_idx = (req_op_i inside {mfc_pkg::OP_MTSRIN, mfc_pkg::OP_MFSRIN}) ?
      req_rb_i[`MFC_SEG_HI:`MFC_SEG_LO] : req_sr_i;
   assign sel_val = s_ff.seg[sel_idx];

   // Fault classification; alignment outranks storage so one exception is raised.
   always_comb begin
      f_align = 1'b0;
      f_dsi = 1'b0;
      f_dfs = 32'h0000_0000;
      if (req_op_i == mfc_pkg::OP_ZERO_BLOCK && (lock || (dte && (attr_wt_i || attr_ci_i)))) begin
         f_align = 1'b1;
      end
      if (req_op_i == mfc_pkg::OP_MULTI_STRING && little_endian_mode_i) begin
         f_align = 1'b1;
      end
      if (dte && fp_op && seg_t) begin
         f_align = 1'b1;
      end
      if (dte && (fp_op || resv_op || req_op_i inside {mfc_pkg::OP_LOAD,
            mfc_pkg::OP_STORE}) && misal) begin
         f_align = 1'b1;
      end
      // Storage checks exist only with translation on.
      if (dte && !f_align) begin
         if ((resv_op && (attr_wt_i || seg_t)) || (ext_op && seg_t)) begin
            f_dsi = 1'b1;
            f_dfs[`MFC_DFS_RESV] = 1'b1;
         end
         if (ext_op && !ext_access_enable_i) begin
            f_dsi = 1'b1;
            f_dfs[`MFC_DFS_EXT_CTL] = 1'b1;
         end
      end
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.sa = {snoop_sync_i, snoop_inv_i, bus_gnt_i, ds_err_i};
      nxt_s.sb = s_ff.sa;
      nxt_s.sc = s_ff.sb;
      nxt_s.saddr_a = snoop_addr_i;
      nxt_s.saddr_b = s_ff.saddr_a;
      nxt_s.align = 1'b0;
      nxt_s.dsi = 1'b0;
      nxt_s.illegal = 1'b0;
      nxt_s.rd_valid = 1'b0;
      nxt_s.mem_ok = 1'b0;
      nxt_s.ds_acc = 1'b0;
      nxt_s.inval = 1'b0;
      nxt_s.ssync = s_ff.sb[3] && !s_ff.sc[3];
      if (ds_ev) begin
         nxt_s.dsi = 1'b1;
         nxt_s.dfs = 32'h0000_0000;
         nxt_s.dfs[`MFC_DFS_DS_ERR] = 1'b1;
      end
      if (take) begin
         case (req_op_i)
            mfc_pkg::OP_MTSR, mfc_pkg::OP_MTSRIN: begin
               nxt_s.seg[sel_idx] = req_rs_i;
            end
            mfc_pkg::OP_MFSR, mfc_pkg::OP_MFSRIN: begin
               nxt_s.rd_valid = 1'b1;
               nxt_s.rd_data = sel_val;
            end
            mfc_pkg::OP_TLB_INVAL: begin
               nxt_s.inval = 1'b1;
               nxt_s.inval_idx = req_ea_i[`MFC_CC_HI:`MFC_CC_LO];
               nxt_s.bus_req = 1'b1;
               nxt_s.bus_cmd = mfc_pkg::BUS_INVAL;
               nxt_s.bus_addr = req_ea_i;
               nxt_s.ready = 1'b0;
               nxt_s.st = mfc_pkg::ST_BUS_WAIT;
            end
            mfc_pkg::OP_TLB_SYNC: begin
               nxt_s.bus_req = 1'b1;
               nxt_s.bus_cmd = mfc_pkg::BUS_SYNC;
               nxt_s.bus_addr = 32'h0000_0000;
               nxt_s.ready = 1'b0;
               nxt_s.st = mfc_pkg::ST_BUS_WAIT;
            end
            mfc_pkg::OP_TLB_INVAL_ALL: begin
               nxt_s.illegal = 1'b1;
            end
            default: begin
               if (mem_op) begin
                  nxt_s.align = f_align;
                  nxt_s.dsi = f_dsi || ds_ev;
                  if (f_dsi) begin
                     nxt_s.dfs = f_dfs | (ds_ev ? nxt_s.dfs : 32'h0000_0000);
                  end
                  nxt_s.mem_ok = !f_align && !f_dsi;
                  nxt_s.ds_acc = !f_align && !f_dsi && dte && seg_t;
               end
            end
         endcase
      end
      // A local invalidate wins the cycle; the snooped one stays pending one more cycle.
      if (inv_ev) begin
         if (take && req_op_i == mfc_pkg::OP_TLB_INVAL) begin
            nxt_s.sc[2] = 1'b0;
         end else begin
            nxt_s.inval = 1'b1;
            nxt_s.inval_idx = s_ff.saddr_b[`MFC_CC_HI:`MFC_CC_LO];
         end
      end
      case (s_ff.st)
         mfc_pkg::ST_IDLE: begin
         end
         mfc_pkg::ST_BUS_WAIT: begin
            if (s_ff.sb[1]) begin
               nxt_s.bus_req = 1'b0;
               nxt_s.bus_cmd = mfc_pkg::BUS_IDLE;
               nxt_s.st = mfc_pkg::ST_BUS_DONE;
            end
         end
         mfc_pkg::ST_BUS_DONE: begin
            // Wait for the grant to fall so one grant never ends two operations.
            if (!s_ff.sb[1]) begin
               nxt_s.ready = 1'b1;
               nxt_s.st = mfc_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_s.st = mfc_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_ff <= '0;
         s_ff.st <= mfc_pkg::ST_IDLE;
         s_ff.seg <= {16{`MFC_SEG_RST}};
         s_ff.dfs <= `MFC_DFS_RST;
         s_ff.ready <= 1'b1;
         s_ff.bus_cmd <= mfc_pkg::BUS_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign req_ready_o = s_ff.ready;
   assign align_exc_o = s_ff.align;
   assign dsi_exc_o = s_ff.dsi;
   assign data_fault_status_o = s_ff.dfs;
   assign illegal_o = s_ff.illegal;
   assign rd_valid_o = s_ff.rd_valid;
   assign rd_data_o = s_ff.rd_data;
   assign mem_ok_o = s_ff.mem_ok;
   assign ds_access_o = s_ff.ds_acc;
   assign tlb_inval_o = s_ff.inval;
   assign tlb_inval_idx_o = s_ff.inval_idx;
   assign snoop_sync_o = s_ff.ssync;
   assign bus_req_o = s_ff.bus_req;
   assign bus_cmd_o = s_ff.bus_cmd;
   assign bus_addr_o = s_ff.bus_addr;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   property p_dr_off;
      take && !dte && !ds_ev |=> !dsi_exc_o;
   endproperty
   a_dr_off: assert property (p_dr_off) else $error("storage fault with translation off");
   property p_zero_wi;
      take && req_op_i == mfc_pkg::OP_ZERO_BLOCK && dte && (attr_wt_i || attr_ci_i)
         |=> align_exc_o && !mem_ok_o;
   endproperty
   a_zero_wi: assert property (p_zero_wi) else $error("zero-block attribute fault missed");
   property p_zero_lock;
      take && req_op_i == mfc_pkg::OP_ZERO_BLOCK && lock |=> align_exc_o;
   endproperty
   a_zero_lock: assert property (p_zero_lock) else $error("zero-block lock fault missed");
   property p_resv_wt;
      take && resv_op && dte && attr_wt_i && !misal |=> dsi_exc_o
         && data_fault_status_o[`MFC_DFS_RESV];
   endproperty
   a_resv_wt: assert property (p_resv_wt) else $error("reservation fault missed");
   property p_ext_ds;
      take && ext_op && dte && seg_t |=> dsi_exc_o && data_fault_status_o[`MFC_DFS_RESV];
   endproperty
   a_ext_ds: assert property (p_ext_ds) else $error("direct-store control fault missed");
   property p_ds_err;
      ds_ev |=> dsi_exc_o && data_fault_status_o[`MFC_DFS_DS_ERR];
   endproperty
   a_ds_err: assert property (p_ds_err) else $error("direct-store error not reported");
   property p_ext_off;
      take && ext_op && dte && !ext_access_enable_i |=> dsi_exc_o
         && data_fault_status_o[`MFC_DFS_EXT_CTL];
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("access-disabled fault missed");
   property p_multi_le;
      take && req_op_i == mfc_pkg::OP_MULTI_STRING && little_endian_mode_i |=> align_exc_o;
   endproperty
   a_multi_le: assert property (p_multi_le) else $error("little-endian string fault missed");
   property p_inval_all;
      take && req_op_i == mfc_pkg::OP_TLB_INVAL_ALL |=> illegal_o && !bus_req_o;
   endproperty
   a_inval_all: assert property (p_inval_all) else $error("invalidate-all not trapped");
   property p_seg_rw;
      take && req_op_i == mfc_pkg::OP_MTSR ##1 take && req_op_i == mfc_pkg::OP_MFSR
         && req_sr_i == $past(req_sr_i) |=> rd_valid_o && rd_data_o == $past(req_rs_i, 2);
   endproperty
   a_seg_rw: assert property (p_seg_rw) else $error("segment register readback wrong");
   property p_inval;
      take && req_op_i == mfc_pkg::OP_TLB_INVAL |=> tlb_inval_o && bus_req_o
         && bus_cmd_o == mfc_pkg::BUS_INVAL && !req_ready_o;
   endproperty
   a_inval: assert property (p_inval) else $error("invalidate not issued");
   property p_sync;
      take && req_op_i == mfc_pkg::OP_TLB_SYNC |=> bus_req_o && bus_cmd_o == mfc_pkg::BUS_SYNC;
   endproperty
   a_sync: assert property (p_sync) else $error("sync not issued on bus");
   property p_no_update;
      align_exc_o |-> !mem_ok_o && !ds_access_o;
   endproperty
   a_no_update: assert property (p_no_update) else $error("faulting access updated state");
   c_align: cover property (take ##1 align_exc_o);
   c_dsi: cover property (take ##1 dsi_exc_o);
   c_bus: cover property (bus_req_o ##[1:20] !bus_req_o);
   c_snoop: cover property (inv_ev ##1 tlb_inval_o);
endmodule

// File: mfc_regs.svh
// Constants of the memory-management fault and control unit.
// Assumes big-endian bit numbering in the architecture, mapped here to [31:0].
`ifndef MFC_REGS_SVH
`define MFC_REGS_SVH
// Fault status bit positions (architected bit n sits at 31-n).
`define MFC_DFS_DS_ERR 31
`define MFC_DFS_RESV 26
`define MFC_DFS_EXT_CTL 20
// Direct-store select bit of a segment descriptor.
`define MFC_SEG_T 31
// Data cache lock bits of the configuration word.
`define MFC_CFG_LOCK_A 13
`define MFC_CFG_LOCK_B 12
// Segment index field of an address or indirect source.
`define MFC_SEG_HI 31
`define MFC_SEG_LO 28
// Congruence class index field of the effective address.
`define MFC_CC_HI 17
`define MFC_CC_LO 12
`define MFC_CC_W 6
`define MFC_SEG_RST 32'h0000_0000
`define MFC_DFS_RST 32'h0000_0000
`endif

// File: mfc_pkg.sv
// Types of the memory-management fault and control unit.
// Assumes the includer also reads mfc_regs.svh for numeric constants.
package mfc_pkg;
   typedef enum logic [4:0] {
      OP_NONE, OP_LOAD, OP_STORE, OP_FP_LOAD, OP_FP_STORE, OP_LOAD_RESERVE,
      OP_STORE_COND, OP_EXT_IN, OP_EXT_OUT, OP_MULTI_STRING, OP_ZERO_BLOCK,
      OP_MTSR, OP_MTSRIN, OP_MFSR, OP_MFSRIN, OP_TLB_INVAL, OP_TLB_SYNC,
      OP_TLB_INVAL_ALL
   } mfc_op_t;
   typedef enum logic [1:0] {BUS_IDLE, BUS_INVAL, BUS_SYNC} mfc_bus_t;
   typedef enum logic [1:0] {ST_IDLE, ST_BUS_WAIT, ST_BUS_DONE} mfc_st_t;
endpackage

// File: mfc_bus_peer.sv
// Shared-bus peer that grants TLB broadcasts and records what it snooped.
// Assumes a requester that holds bus_req_i and its command until the grant.
`timescale 1ns/1ps
module mfc_bus_peer (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic bus_req_i,
   input wire mfc_pkg::mfc_bus_t bus_cmd_i,
   input wire logic [31:0] bus_addr_i,
   output logic bus_gnt_o,
   output logic [31:0] last_addr_o,
   output logic [7:0] n_inval_o,
   output logic [7:0] n_sync_o
);
   logic [3:0] wait_ff;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         bus_gnt_o <= 1'b0;
         wait_ff <= 4'h0;
         n_inval_o <= 8'h0;
         n_sync_o <= 8'h0;
         last_addr_o <= 32'h0;
      end else if (!bus_req_i) begin
         bus_gnt_o <= 1'b0;
         wait_ff <= 4'h0;
      end else if (!bus_gnt_o) begin
         wait_ff <= wait_ff + 4'h1;
         // A slow arbiter stretches the time the requester must stay not ready.
         if (wait_ff >= (slow_i ? 4'h7 : 4'h0)) begin
            bus_gnt_o <= 1'b1;
            last_addr_o <= bus_addr_i;
            n_inval_o <= n_inval_o + {7'h0, bus_cmd_i == mfc_pkg::BUS_INVAL};
            n_sync_o <= n_sync_o + {7'h0, bus_cmd_i == mfc_pkg::BUS_SYNC};
         end
      end
   end
endmodule

// File: testbench.sv
// Self-checking bench for the memory-management fault and control unit.
// Assumes mfc_pkg and mfc_unit compiled first; the bus peer grants broadcasts.
`timescale 1ns/1ps
module testbench;
   // Result nibbles: align, dsi, illegal, mem_ok, direct-store, invalidate, read, sync.
   localparam logic [31:0] R_AL = 32'h1000_0000, R_DS = 32'h0100_0000, R_IL = 32'h0010_0000;
   localparam logic [31:0] R_OK = 32'h0001_0000, R_DA = 32'h0000_1000, R_IN = 32'h0000_0100;
   localparam logic [31:0] R_RD = 32'h0000_0010, R_SS = 32'h0000_0001, DS_EA = 32'h5000_0000;
   logic clk = 1'b0, rst = 1'b1, valid = 1'b0, wt = 1'b0, ci = 1'b0, dr = 1'b0, le = 1'b0;
   logic ee = 1'b1, dserr = 1'b0, s_inv = 1'b0, s_sync = 1'b0, slow = 1'b0;
   mfc_pkg::mfc_op_t op = mfc_pkg::OP_NONE;
   logic [31:0] ea = 32'h0, rs = 32'h0, rb = 32'h0, cfg = 32'h0, s_addr = 32'h0, res;
   logic [1:0] sz = 2'h0;
   logic [3:0] sr = 4'h0;
   logic ready, align, dsi, ill, rdv, ok, dsa, inv, ssync, breq, gnt;
   logic [31:0] dfs, rdata, baddr, paddr;
   logic [5:0] idx;
   mfc_pkg::mfc_bus_t bcmd;
   logic [7:0] n_inv, n_sync;
   int bad_count = 0, check_count = 0, cycles = 0;
   mfc_unit u_dut (.clk_sys_i(clk), .rst_i(rst), .req_valid_i(valid), .req_op_i(op),
      .req_ea_i(ea), .req_size_i(sz), .req_rs_i(rs), .req_rb_i(rb), .req_sr_i(sr),
      .attr_wt_i(wt), .attr_ci_i(ci), .data_translate_enable_i(dr),
      .little_endian_mode_i(le), .ext_access_enable_i(ee), .hw_impl_config_i(cfg),
      .ds_err_i(dserr), .bus_gnt_i(gnt), .snoop_inv_i(s_inv), .snoop_sync_i(s_sync),
      .snoop_addr_i(s_addr), .req_ready_o(ready), .align_exc_o(align), .dsi_exc_o(dsi),
      .data_fault_status_o(dfs), .illegal_o(ill), .rd_valid_o(rdv), .rd_data_o(rdata),
      .mem_ok_o(ok), .ds_access_o(dsa), .tlb_inval_o(inv), .tlb_inval_idx_o(idx),
      .snoop_sync_o(ssync), .bus_req_o(breq), .bus_cmd_o(bcmd), .bus_addr_o(baddr));
   mfc_bus_peer u_peer (.clk_sys_i(clk), .rst_i(rst), .slow_i(slow), .bus_req_i(breq),
      .bus_cmd_i(bcmd), .bus_addr_i(baddr), .bus_gnt_o(gnt), .last_addr_o(paddr),
      .n_inval_o(n_inv), .n_sync_o(n_sync));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic give_verdict();
      if (bad_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         bad_count = bad_count + 1;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   // Counting over several cycles catches both a missing pulse and a doubled one.
   task automatic watch(input int n);
      res = 32'h0;
      repeat (n) begin
         res = res + {3'h0, align, 3'h0, dsi, 3'h0, ill, 3'h0, ok, 3'h0, dsa, 3'h0, inv,
            3'h0, rdv, 3'h0, ssync};
         step();
      end
   endtask
   task automatic ex(input mfc_pkg::mfc_op_t o, input logic [31:0] a, input logic [1:0] s,
      input logic [31:0] exp);
      valid = 1'b1;
      op = o;
      ea = a;
      sz = s;
      step();
      valid = 1'b0;
      watch(3);
      chk(res, exp);
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 60 && ready !== 1'b1; i++) begin
         step();
      end
   endtask
   task automatic t_seg();
      chk({ready, breq, dfs[29:0]}, 32'h8000_0000);
      sr = 4'h3;
      rs = 32'h1234_5678;
      ex(mfc_pkg::OP_MTSR, 32'h0, 2'h0, 32'h0);
      rb = 32'h5fff_ffff;
      rs = 32'h8000_0055;
      ex(mfc_pkg::OP_MTSRIN, 32'h0, 2'h0, 32'h0);
      sr = 4'hf;
      rs = 32'hcafe_0f0f;
      ex(mfc_pkg::OP_MTSR, 32'h0, 2'h0, 32'h0);
      ex(mfc_pkg::OP_MFSR, 32'h0, 2'h0, R_RD);
      chk(rdata, 32'hcafe_0f0f);
      sr = 4'h3;
      ex(mfc_pkg::OP_MFSRIN, 32'h0, 2'h0, R_RD);
      chk(rdata, 32'h8000_0055);
      ex(mfc_pkg::OP_MFSR, 32'h0, 2'h0, R_RD);
      chk(rdata, 32'h1234_5678);
      sr = 4'h1;
      ex(mfc_pkg::OP_MFSR, 32'h0, 2'h0, R_RD);
      chk(rdata, 32'h0);
      // A read right behind the write must already see the new segment value.
      valid = 1'b1;
      op = mfc_pkg::OP_MTSR;
      sr = 4'h7;
      rs = 32'h0a5a_c3c3;
      step();
      op = mfc_pkg::OP_MFSR;
      step();
      valid = 1'b0;
      chk({31'h0, rdv}, 32'h1);
      chk(rdata, 32'h0a5a_c3c3);
   endtask
   task automatic t_checks();
      wt = 1'b1;
      ex(mfc_pkg::OP_LOAD, 32'h2, 2'h2, R_OK);
      ex(mfc_pkg::OP_LOAD_RESERVE, 32'h0, 2'h2, R_OK);
      dr = 1'b1;
      ex(mfc_pkg::OP_ZERO_BLOCK, 32'h0, 2'h0, R_AL);
      ex(mfc_pkg::OP_LOAD_RESERVE, 32'h0, 2'h2, R_DS);
      chk(dfs, 32'h0400_0000);
      ex(mfc_pkg::OP_STORE_COND, 32'h0, 2'h2, R_DS);
      wt = 1'b0;
      ci = 1'b1;
      ex(mfc_pkg::OP_ZERO_BLOCK, 32'h0, 2'h0, R_AL);
      ci = 1'b0;
      cfg = 32'h0000_2000;
      ex(mfc_pkg::OP_ZERO_BLOCK, 32'h0, 2'h0, R_OK);
      cfg = 32'h0000_3000;
      ex(mfc_pkg::OP_ZERO_BLOCK, 32'h0, 2'h0, R_AL);
      cfg = 32'h0;
      le = 1'b1;
      ex(mfc_pkg::OP_MULTI_STRING, 32'h0, 2'h2, R_AL);
      le = 1'b0;
      ex(mfc_pkg::OP_LOAD, 32'h2, 2'h2, R_AL);
      ex(mfc_pkg::OP_STORE, 32'h6, 2'h3, R_AL);
      ex(mfc_pkg::OP_STORE, 32'h1, 2'h0, R_OK);
      ex(mfc_pkg::OP_LOAD, 32'h8, 2'h3, R_OK);
   endtask
   task automatic t_direct();
      ex(mfc_pkg::OP_LOAD_RESERVE, DS_EA, 2'h2, R_DS);
      ex(mfc_pkg::OP_EXT_OUT, DS_EA, 2'h2, R_DS);
      ee = 1'b0;
      ex(mfc_pkg::OP_EXT_IN, 32'h0, 2'h2, R_DS);
      chk(dfs, 32'h0010_0000);
      ex(mfc_pkg::OP_EXT_IN, DS_EA, 2'h2, R_DS);
      chk(dfs, 32'h0410_0000);
      ee = 1'b1;
      ex(mfc_pkg::OP_FP_LOAD, DS_EA, 2'h3, R_AL);
      ex(mfc_pkg::OP_FP_STORE, DS_EA, 2'h2, R_AL);
      ex(mfc_pkg::OP_FP_LOAD, 32'h0, 2'h3, R_OK);
      ex(mfc_pkg::OP_LOAD, DS_EA, 2'h2, R_OK + R_DA);
      dserr = 1'b1;
      watch(6);
      chk(res, R_DS);
      chk(dfs, 32'h8000_0000);
      dserr = 1'b0;
   endtask
   task automatic t_tlb();
      ex(mfc_pkg::OP_TLB_INVAL_ALL, 32'h0002_b000, 2'h0, R_IL);
      chk({24'h0, n_inv}, 32'h0);
      // Every earlier access has completed before the invalidate is issued.
      ex(mfc_pkg::OP_TLB_INVAL, 32'h0002_b000, 2'h0, R_IN);
      chk({26'h0, idx}, 32'h0000_002b);
      wait_ready();
      chk({n_inv, paddr[23:0]}, 32'h0102_b000);
      slow = 1'b1;
      ex(mfc_pkg::OP_TLB_SYNC, 32'h0, 2'h0, 32'h0);
      ex(mfc_pkg::OP_LOAD, 32'h2, 2'h2, 32'h0);
      wait_ready();
      chk({n_sync, n_inv, 12'h0, bcmd, ready, breq}, 32'h0101_0002);
      s_addr = 32'h0003_f000;
      s_inv = 1'b1;
      watch(6);
      chk(res, R_IN);
      chk({26'h0, idx}, 32'h0000_003f);
      s_inv = 1'b0;
      // A released snoop address must not look as if it still held the old value.
      s_addr = ~s_addr;
      s_sync = 1'b1;
      watch(6);
      chk(res, R_SS);
      s_sync = 1'b0;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      t_seg();
      t_checks();
      t_direct();
      t_tlb();
      give_verdict();
   end
endmodule
